// >>> common/ctpcp_pkg.sv
// shared constants and types for the compact test port front end
package ctpcp_pkg;
	// tap controller states
	typedef enum logic [3:0] {
		TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PA_DR, TAP_EX2_DR, TAP_UPD_DR,
		TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR, TAP_UPD_IR
	} ctpcp_tap_t;
	// protocol mode
	typedef enum logic {
		MODE_STANDARD, MODE_ADVANCED
	} ctpcp_mode_t;
	// check packet phase
	typedef enum logic [1:0] {
		PKT_NONE, PKT_PREAMBLE, PKT_BODY
	} ctpcp_pkt_t;
	// observable port status
	typedef struct packed {
		logic advanced;
		logic pkt_active;
		logic in_preamble;
		logic in_body;
		logic tck_gated;
		logic [3:0] tap_state;
	} ctpcp_status_t;
	localparam int SYNC_STAGES = 2;
	localparam int PREAMBLE_TCKS = 2;
	localparam int BODY_TCKS = 8;
	localparam int CNT_W = 8;
endpackage

// >>> src/ctpcp_sync.sv
// two-flop synchroniser with edge detection on the settled value
module ctpcp_sync (
	input wire logic CLOCK_I,
	input wire logic RST_I,
	input wire logic d_i,
	output logic q_o,
	output logic rise_o,
	output logic fall_o
);
	logic meta;
	logic sync;
	logic prev;
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			meta <= 1'b0;
			sync <= 1'b0;
			prev <= 1'b0;
		end else begin
			meta <= d_i;
			sync <= meta;
			prev <= sync;
		end
	end
	assign q_o = sync;
	assign rise_o = sync & ~prev;
	assign fall_o = ~sync & prev;
endmodule

// >>> src/ctpcp_top.sv
// compact two-pin test port front end: mode change and check packet gating
// Behaviour
// - tool can switch standard to advanced protocol
// - self reset clears mode, packet, gate and tap registers, mode standard
// - gate tap clock during check packet
// - preamble then body, gating stays glitch free
module ctpcp_top #(
	parameter int PREAMBLE_TCKS = ctpcp_pkg::PREAMBLE_TCKS,
	parameter int BODY_TCKS = ctpcp_pkg::BODY_TCKS
) (
	input wire logic CLOCK_I,
	input wire logic RST_I,
	input wire logic TCK_I,
	input wire logic TMS_I,
	input wire logic ADV_REQ_I,
	input wire logic CHK_REQ_I,
	input wire logic SELF_RESET_I,
	output logic ADVANCED_O,
	output logic GATED_TCK_O,
	output logic RESET_SEEN_O,
	output ctpcp_pkg::ctpcp_status_t STATUS_O
);
	// ==========================================================
	// pin synchronisers
	logic tck_s;
	logic tck_rise;
	logic tck_fall;
	logic tms_s;
	logic adv_s;
	logic chk_s;
	logic srst_s;
	logic adv_rise;
	logic chk_rise;
	logic srst_rise;
	ctpcp_sync u_tck (
		.CLOCK_I(CLOCK_I),
		.RST_I(RST_I),
		.d_i(TCK_I),
		.q_o(tck_s),
		.rise_o(tck_rise),
		.fall_o(tck_fall)
	);
	ctpcp_sync u_tms (
		.CLOCK_I(CLOCK_I),
		.RST_I(RST_I),
		.d_i(TMS_I),
		.q_o(tms_s),
		.rise_o(),
		.fall_o()
	);
	ctpcp_sync u_adv (
		.CLOCK_I(CLOCK_I),
		.RST_I(RST_I),
		.d_i(ADV_REQ_I),
		.q_o(adv_s),
		.rise_o(adv_rise),
		.fall_o()
	);
	ctpcp_sync u_chk (
		.CLOCK_I(CLOCK_I),
		.RST_I(RST_I),
		.d_i(CHK_REQ_I),
		.q_o(chk_s),
		.rise_o(chk_rise),
		.fall_o()
	);
	ctpcp_sync u_srst (
		.CLOCK_I(CLOCK_I),
		.RST_I(RST_I),
		.d_i(SELF_RESET_I),
		.q_o(srst_s),
		.rise_o(srst_rise),
		.fall_o()
	);

	// ==========================================================
	// internal reset: block reset or self reset
	logic int_rst;
	assign int_rst = RST_I | srst_rise;

	// ==========================================================
	// protocol mode
	ctpcp_pkg::ctpcp_mode_t mode;
	always_ff @(posedge CLOCK_I) begin
		if (int_rst) begin
			mode <= ctpcp_pkg::MODE_STANDARD;
		end else if (adv_rise) begin
			mode <= ctpcp_pkg::MODE_ADVANCED;
		end
	end

	// indication that the port reset itself, cleared by block reset or an advanced request
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			RESET_SEEN_O <= 1'b0;
		end else if (srst_rise) begin
			RESET_SEEN_O <= 1'b1;
		end else if (adv_rise) begin
			RESET_SEEN_O <= 1'b0;
		end
	end

	// ==========================================================
	// check packet sequencer, counted in falling tck edges
	ctpcp_pkg::ctpcp_pkt_t pkt;
	logic [ctpcp_pkg::CNT_W-1:0] cnt;
	logic pkt_pend;
	ctpcp_pkg::ctpcp_tap_t tap;
	ctpcp_pkg::ctpcp_tap_t next_tap;
	always_ff @(posedge CLOCK_I) begin
		if (int_rst) begin
			pkt_pend <= 1'b0;
		end else if (chk_rise && mode == ctpcp_pkg::MODE_ADVANCED) begin
			pkt_pend <= 1'b1;
		end else if (pkt == ctpcp_pkg::PKT_PREAMBLE) begin
			pkt_pend <= 1'b0;
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (int_rst) begin
			pkt <= ctpcp_pkg::PKT_NONE;
			cnt <= '0;
		end else if (tck_fall) begin
			case (pkt)
				ctpcp_pkg::PKT_NONE: begin
					if (pkt_pend && tap == ctpcp_pkg::TAP_IDLE) begin
						pkt <= ctpcp_pkg::PKT_PREAMBLE;
						cnt <= '0;
					end
				end
				ctpcp_pkg::PKT_PREAMBLE: begin
					if (cnt == ctpcp_pkg::CNT_W'(PREAMBLE_TCKS - 1)) begin
						pkt <= ctpcp_pkg::PKT_BODY;
						cnt <= '0;
					end else begin
						cnt <= cnt + 1'b1;
					end
				end
				ctpcp_pkg::PKT_BODY: begin
					if (cnt == ctpcp_pkg::CNT_W'(BODY_TCKS - 1)) begin
						pkt <= ctpcp_pkg::PKT_NONE;
						cnt <= '0;
					end else begin
						cnt <= cnt + 1'b1;
					end
				end
				default: begin
					pkt <= ctpcp_pkg::PKT_NONE;
					cnt <= '0;
				end
			endcase
		end
	end

	// ==========================================================
	// gate enable: changes on falling tck, while the clock is low, or on internal reset,
	// and stays asserted over the preamble to body step
	logic gate;
	always_ff @(posedge CLOCK_I) begin
		if (int_rst) begin
			gate <= 1'b0;
		end else if (tck_fall) begin
			gate <= (pkt != ctpcp_pkg::PKT_NONE) || (pkt_pend && tap == ctpcp_pkg::TAP_IDLE);
		end
	end

	// registered gated clock, low while gated
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			GATED_TCK_O <= 1'b0;
		end else begin
			GATED_TCK_O <= tck_s & ~gate;
		end
	end

	// ==========================================================
	// tap controller, advanced on rising tck unless gated
	always_comb begin
		next_tap = tap;
		case (tap)
			ctpcp_pkg::TAP_RESET: next_tap = tms_s ? ctpcp_pkg::TAP_RESET : ctpcp_pkg::TAP_IDLE;
			ctpcp_pkg::TAP_IDLE: next_tap = tms_s ? ctpcp_pkg::TAP_SEL_DR : ctpcp_pkg::TAP_IDLE;
			ctpcp_pkg::TAP_SEL_DR: next_tap = tms_s ? ctpcp_pkg::TAP_SEL_IR : ctpcp_pkg::TAP_CAP_DR;
			ctpcp_pkg::TAP_CAP_DR: next_tap = tms_s ? ctpcp_pkg::TAP_EX1_DR : ctpcp_pkg::TAP_SH_DR;
			ctpcp_pkg::TAP_SH_DR: next_tap = tms_s ? ctpcp_pkg::TAP_EX1_DR : ctpcp_pkg::TAP_SH_DR;
			ctpcp_pkg::TAP_EX1_DR: next_tap = tms_s ? ctpcp_pkg::TAP_UPD_DR : ctpcp_pkg::TAP_PA_DR;
			ctpcp_pkg::TAP_PA_DR: next_tap = tms_s ? ctpcp_pkg::TAP_EX2_DR : ctpcp_pkg::TAP_PA_DR;
			ctpcp_pkg::TAP_EX2_DR: next_tap = tms_s ? ctpcp_pkg::TAP_UPD_DR : ctpcp_pkg::TAP_SH_DR;
			ctpcp_pkg::TAP_UPD_DR: next_tap = tms_s ? ctpcp_pkg::TAP_SEL_DR : ctpcp_pkg::TAP_IDLE;
			ctpcp_pkg::TAP_SEL_IR: next_tap = tms_s ? ctpcp_pkg::TAP_RESET : ctpcp_pkg::TAP_CAP_IR;
			ctpcp_pkg::TAP_CAP_IR: next_tap = tms_s ? ctpcp_pkg::TAP_EX1_IR : ctpcp_pkg::TAP_SH_IR;
			ctpcp_pkg::TAP_SH_IR: next_tap = tms_s ? ctpcp_pkg::TAP_EX1_IR : ctpcp_pkg::TAP_SH_IR;
			ctpcp_pkg::TAP_EX1_IR: next_tap = tms_s ? ctpcp_pkg::TAP_UPD_IR : ctpcp_pkg::TAP_PA_IR;
			ctpcp_pkg::TAP_PA_IR: next_tap = tms_s ? ctpcp_pkg::TAP_EX2_IR : ctpcp_pkg::TAP_PA_IR;
			ctpcp_pkg::TAP_EX2_IR: next_tap = tms_s ? ctpcp_pkg::TAP_UPD_IR : ctpcp_pkg::TAP_SH_IR;
			ctpcp_pkg::TAP_UPD_IR: next_tap = tms_s ? ctpcp_pkg::TAP_SEL_DR : ctpcp_pkg::TAP_IDLE;
			default: next_tap = ctpcp_pkg::TAP_RESET;
		endcase
	end

	always_ff @(posedge CLOCK_I) begin
		if (int_rst) begin
			tap <= ctpcp_pkg::TAP_RESET;
		end else if (tck_rise && !gate) begin
			tap <= next_tap;
		end
	end

	// ==========================================================
	// status outputs
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			ADVANCED_O <= 1'b0;
			STATUS_O <= '0;
		end else begin
			ADVANCED_O <= (mode == ctpcp_pkg::MODE_ADVANCED);
			STATUS_O.advanced <= (mode == ctpcp_pkg::MODE_ADVANCED);
			STATUS_O.pkt_active <= (pkt != ctpcp_pkg::PKT_NONE);
			STATUS_O.in_preamble <= (pkt == ctpcp_pkg::PKT_PREAMBLE);
			STATUS_O.in_body <= (pkt == ctpcp_pkg::PKT_BODY);
			STATUS_O.tck_gated <= gate;
			STATUS_O.tap_state <= tap;
		end
	end
endmodule

// >>> verif/compact_test_port_check_packet_test.sv
// testbench for the compact test port front end
module compact_test_port_check_packet_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0, rst = 1'b1, adv = 1'b0, chk = 1'b0, srst = 1'b0, hold = 1'b0;
	logic tck, tms, advanced, gtck, seen;
	ctpcp_pkg::ctpcp_status_t st;
	int n_fail = 0, total_checks = 0, cycles = 0, ghigh = 0;
	ctpcp_top u_ctpcp_top (.CLOCK_I(clk), .RST_I(rst), .TCK_I(tck), .TMS_I(tms), .ADV_REQ_I(adv),
		.CHK_REQ_I(chk), .SELF_RESET_I(srst), .ADVANCED_O(advanced), .GATED_TCK_O(gtck),
		.RESET_SEEN_O(seen), .STATUS_O(st));
	ctpcp_tool u_ctpcp_tool (.hold_low_i(hold), .tck_o(tck), .tms_o(tms));
	// ====
	// helpers
	initial begin
		forever #2 clk = ~clk;
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic check(input logic [8:0] got, input logic [8:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one clock period then time for the status to settle
	task automatic tool(input logic t);
		u_ctpcp_tool.step(t);
		repeat (6) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic req(input int which);
		@(posedge clk);
		if (which == 0) adv <= 1'b1; else if (which == 1) chk <= 1'b1; else srst <= 1'b1;
		repeat (8) @(posedge clk);
		adv <= 1'b0;
		chk <= 1'b0;
		srst <= 1'b0;
		@(negedge clk);
	endtask
	// ====
	// scenarios
	task automatic tap_walk();
		int g0;
		g0 = ghigh;
		for (int i = 0; i < 7; i++) begin
			tool(1'(7'h32 >> i));
			check({5'h00, st.tap_state}, {5'h00, 4'(28'h1854321 >> (4 * i))});
		end
		check({8'h00, ghigh > g0}, 9'h001);
		$display("tap walk done");
	endtask
	task automatic mode_packet();
		int nbody;
		int g0;
		nbody = 0;
		req(0);
		check({8'h00, advanced}, 9'h001);
		req(1);
		tool(1'b0);
		g0 = ghigh;
		for (int i = 2; i <= 11; i++) begin
			hold = (i <= 1 + ctpcp_pkg::PREAMBLE_TCKS);
			tool(1'b1);
			check({4'h0, st.tck_gated, st.tap_state}, 9'h011);
			if (st.in_body === 1'b1) nbody++;
		end
		hold = 1'b0;
		check(9'(nbody), 9'(ctpcp_pkg::BODY_TCKS));
		tool(1'b0);
		check(9'(ghigh - g0), 9'h000);
		tool(1'b1);
		check({5'h00, st.tap_state}, 9'h002);
		$display("mode and packet done");
	endtask
	task automatic self_reset();
		req(2);
		check({2'h0, advanced, seen, st.advanced, st.tap_state}, 9'h020);
		req(1);
		tool(1'b0);
		tool(1'b1);
		check({4'h0, st.pkt_active, st.tap_state}, 9'h002);
		req(0);
		check({7'h00, advanced, seen}, 9'h002);
		$display("self reset done");
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		tap_walk();
		mode_packet();
		self_reset();
		summarize();
	end
	always @(posedge clk) begin
		cycles++;
		if (gtck === 1'b1) begin
			ghigh++;
		end
		if (cycles == 5000) begin
			n_fail++;
			$display("timeout");
			summarize();
		end
	end
endmodule
bind ctpcp_top ctpcp_top_sva #(.PREAMBLE_TCKS(PREAMBLE_TCKS), .BODY_TCKS(BODY_TCKS)) u_ctpcp_top_sva (
	.CLOCK_I(CLOCK_I), .RST_I(RST_I), .TCK_I(TCK_I), .TMS_I(TMS_I), .ADV_REQ_I(ADV_REQ_I),
	.CHK_REQ_I(CHK_REQ_I), .SELF_RESET_I(SELF_RESET_I), .ADVANCED_O(ADVANCED_O),
	.GATED_TCK_O(GATED_TCK_O), .RESET_SEEN_O(RESET_SEEN_O), .STATUS_O(STATUS_O));

// >>> verif/ctpcp_tool.sv
// debug tool model driving the test clock and mode select pins
module ctpcp_tool (
	input wire logic hold_low_i,
	output logic tck_o,
	output logic tms_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// ====
	// pins; the clock rests low between steps
	initial begin
		tck_o = 1'b0;
		tms_o = 1'b1;
	end
	task automatic step(input logic t);
		tms_o = hold_low_i ? 1'b0 : t;
		#62.5 tck_o = 1'b1;
		#62.5 tck_o = 1'b0;
	endtask
endmodule

// >>> verif/ctpcp_top_sva.sv
// checker for the compact test port front end
module ctpcp_top_sva #(
	parameter int PREAMBLE_TCKS = 2,
	parameter int BODY_TCKS = 8
) (
	input wire logic CLOCK_I,
	input wire logic RST_I,
	input wire logic TCK_I,
	input wire logic TMS_I,
	input wire logic ADV_REQ_I,
	input wire logic CHK_REQ_I,
	input wire logic SELF_RESET_I,
	input wire logic ADVANCED_O,
	input wire logic GATED_TCK_O,
	input wire logic RESET_SEEN_O,
	input wire ctpcp_pkg::ctpcp_status_t STATUS_O
);
	timeunit 1ns;
	timeprecision 100ps;
	// ====
	// checks
	default clocking @(posedge CLOCK_I);
	endclocking
	default disable iff (RST_I);
	chk_reset_clear: assert property (disable iff (1'b0) RST_I |=> !ADVANCED_O && STATUS_O == 9'h000)
		else $error("not clear");
	chk_pre_gated: assert property (STATUS_O.in_preamble |-> STATUS_O.tck_gated)
		else $error("preamble ungated");
	chk_body_gated: assert property (STATUS_O.in_body |-> STATUS_O.tck_gated)
		else $error("body ungated");
	chk_tap_held: assert property (STATUS_O.tck_gated && $past(STATUS_O.tck_gated) |-> $stable(STATUS_O.tap_state))
		else $error("tap moved");
	chk_pkt_idle: assert property (STATUS_O.pkt_active |-> STATUS_O.tap_state == 4'h1)
		else $error("tap not idle");
	chk_pkt_mode: assert property (STATUS_O.pkt_active |-> STATUS_O.advanced)
		else $error("packet in standard");
	chk_gate_low: assert property (STATUS_O.tck_gated [*3] |-> !GATED_TCK_O)
		else $error("gated clock high");
	chk_pre_body: assert property ($fell(STATUS_O.in_preamble) |-> STATUS_O.in_body)
		else $error("no body");
	chk_seen_std: assert property ($rose(RESET_SEEN_O) |=> !ADVANCED_O)
		else $error("mode kept");
	cover property (STATUS_O.in_body);
	cover property ($rose(ADVANCED_O));
	cover property ($rose(RESET_SEEN_O));
endmodule
